// *** sbl_map.svh ***
// register offsets, reset values and timing figures of the serial slave link
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH
`define SBL_OFS_CTRL     8'h00
`define SBL_OFS_ADDR     8'h04
`define SBL_OFS_RESP     8'h08
`define SBL_OFS_STAT     8'h0C
`define SBL_OFS_RXIDX    8'h10
`define SBL_OFS_RXDATA   8'h14
`define SBL_OFS_TXDATA   8'h18
`define SBL_OFS_TXGO     8'h1C
`define SBL_OFS_BINVAL   8'h20
`define SBL_OFS_ANAVAL   8'h24
`define SBL_RST_ADDR     8'h01
`define SBL_ADDR_MAX     8'hFE
`define SBL_RST_RESP_MS  9'h028
`define SBL_RESP_MAX_MS  9'h1F4
`define SBL_CLK_HZ       25000000
`define SBL_CLK_NS       40
`define SBL_MS_NS        1000000
`define SBL_SILENCE_BITS 6'h27
`define SBL_MIN_FRAME    8'h04
`define SBL_STAT_READY   0
`define SBL_STAT_TXBUSY  1
`define SBL_STAT_ACTIVE  2
`define SBL_STAT_FULL    3
`define SBL_STAT_INIT    4
`endif

// *** sbl_pkg.sv ***
// types shared by the serial slave link files
package sbl_pkg;
  typedef enum logic [1:0] {
    SBL_B9600   = 2'h0,
    SBL_B19200  = 2'h1,
    SBL_B38400  = 2'h2,
    SBL_B115200 = 2'h3
  } sbl_baud_e;
  typedef enum logic [1:0] {
    SBL_F8N1 = 2'h0,
    SBL_F8O1 = 2'h1,
    SBL_F8E1 = 2'h2,
    SBL_F8N2 = 2'h3
  } sbl_fmt_e;
  typedef struct packed {
    logic      en;
    sbl_baud_e baud;
    sbl_fmt_e  fmt;
  } sbl_ctrl_s;
  typedef enum logic [2:0] {
    SBL_RX_IDLE  = 3'b001,
    SBL_RX_START = 3'b010,
    SBL_RX_BITS  = 3'b100
  } sbl_rx_e;
  typedef enum logic [2:0] {
    SBL_TX_IDLE = 3'b001,
    SBL_TX_WAIT = 3'b010,
    SBL_TX_SEND = 3'b100
  } sbl_tx_e;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } sbl_wr_s;
endpackage

// *** sbl_fifo.sv ***
// reply byte fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sbl_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  logic         full;
  logic         empty;

  // pointers carry a wrap bit so full and empty differ
  assign empty     = (wr_reg == rd_reg);
  assign full      = (wr_reg[AW] != rd_reg[AW]) &&
                     (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_reg[AW-1:0]];

  // storage
  always_ff @(posedge pclk) begin
    if (in_valid && !full) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sbl_ram.sv ***
// received frame buffer, 256 bytes, registered read
`timescale 1ns/10ps
`default_nettype none
module sbl_ram (
  // clock
  input  wire logic               pclk,
  // write port
  input  wire sbl_pkg::sbl_wr_s   wr,
  // read port
  input  wire logic [7:0]         rd_addr,
  output logic [7:0]              rd_data
);
  import sbl_pkg::*;
  logic [7:0] mem [256];

  // write then registered read
  always_ff @(posedge pclk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// *** sbl_link.sv ***
// serial slave link: rtu framing, apb registers, reply timing
`timescale 1ns/10ps
`default_nettype none
`include "sbl_map.svh"
module sbl_link #(
  parameter int          CYC_PER_MS = `SBL_MS_NS / `SBL_CLK_NS,
  parameter logic [15:0] ABSENT_MARK = 16'h7FFF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // rs485 line
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             tx_drive_n,
  // device state
  input  wire logic        setup_port_busy,
  input  wire logic        init_busy,
  // link-written inputs toward the controller
  output logic [15:0]      bin_inputs,
  output logic [15:0]      ana_input
);
  import sbl_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [15:0] baud_div(input sbl_baud_e b);
    unique case (b)
      SBL_B9600:   baud_div = 16'(`SBL_CLK_HZ / 9600);
      SBL_B19200:  baud_div = 16'(`SBL_CLK_HZ / 19200);
      SBL_B38400:  baud_div = 16'(`SBL_CLK_HZ / 38400);
      SBL_B115200: baud_div = 16'(`SBL_CLK_HZ / 115200);
    endcase
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    crc_step = r;
  endfunction

  // parity bit for the format; odd makes the count of ones odd
  function automatic logic par_bit(input logic [7:0] d,
                                   input sbl_fmt_e   f);
    par_bit = (f == SBL_F8O1) ? ~(^d) : (^d);
  endfunction

  function automatic logic has_par(input sbl_fmt_e f);
    has_par = (f == SBL_F8O1) || (f == SBL_F8E1);
  endfunction

  // ==========================================================
  // registers and signals
  sbl_ctrl_s   ctrl_reg;
  logic [7:0]  station_reg;
  logic [8:0]  resp_ms_reg;
  logic [7:0]  rx_idx_reg;
  logic [15:0] bin_val_reg;
  logic [15:0] ana_val_reg;
  logic        ready_reg;
  logic [7:0]  flen_reg;
  logic        link_on;
  logic        acc;
  logic        wr_go;
  logic        rd_go;
  logic        wr_tx;
  logic        tx_go;
  logic        clr_ready;
  logic        tx_busy;
  logic [15:0] div;
  logic [7:0]  ram_q;
  logic        fifo_in_rdy;
  logic        fifo_vld;
  logic [7:0]  fifo_q;
  logic        fifo_pop;
  logic        frame_end;
  logic        frame_ok;
  sbl_wr_s     ram_wr;

  assign link_on = ctrl_reg.en && !setup_port_busy;
  assign div     = baud_div(ctrl_reg.baud);

  // ==========================================================
  // apb decode
  assign acc     = psel && penable;
  assign wr_tx   = pwrite && (paddr == `SBL_OFS_TXDATA);
  // a full fifo stalls the writer instead of losing a byte
  assign pready  = !(wr_tx && !fifo_in_rdy);
  assign wr_go   = acc && pready && pwrite;
  assign rd_go   = psel && !penable && !pwrite;
  assign tx_go   = wr_go && (paddr == `SBL_OFS_TXGO) && pwdata[0];
  assign clr_ready = wr_go && (paddr == `SBL_OFS_STAT) &&
                     pwdata[`SBL_STAT_READY];

  // unmapped addresses answer with an error
  always_comb begin
    unique case (paddr)
      `SBL_OFS_CTRL, `SBL_OFS_ADDR, `SBL_OFS_RESP, `SBL_OFS_STAT,
      `SBL_OFS_RXIDX, `SBL_OFS_RXDATA, `SBL_OFS_TXDATA,
      `SBL_OFS_TXGO, `SBL_OFS_BINVAL, `SBL_OFS_ANAVAL:
        pslverr = 1'b0;
      default:
        pslverr = acc;
    endcase
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= '0;
      station_reg <= `SBL_RST_ADDR;
      resp_ms_reg <= `SBL_RST_RESP_MS;
      rx_idx_reg  <= 8'h00;
      bin_val_reg <= 16'h0000;
      ana_val_reg <= 16'h0000;
    end else if (wr_go) begin
      unique case (paddr)
        `SBL_OFS_CTRL:  ctrl_reg <= sbl_ctrl_s'(pwdata[4:0]);
        `SBL_OFS_ADDR:
          if (pwdata[7:0] != 8'h00 && pwdata[7:0] <= `SBL_ADDR_MAX &&
              pwdata[31:8] == 24'h000000) begin
            station_reg <= pwdata[7:0];
          end
        `SBL_OFS_RESP:
          if (pwdata[31:0] <= 32'(`SBL_RESP_MAX_MS)) begin
            resp_ms_reg <= pwdata[8:0];
          end
        `SBL_OFS_RXIDX:  rx_idx_reg  <= pwdata[7:0];
        `SBL_OFS_BINVAL: bin_val_reg <= pwdata[15:0];
        `SBL_OFS_ANAVAL: ana_val_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // read mux, loaded in setup so it stands in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_go) begin
      unique case (paddr)
        `SBL_OFS_CTRL:   prdata <= {27'h0, ctrl_reg};
        `SBL_OFS_ADDR:   prdata <= {24'h0, station_reg};
        `SBL_OFS_RESP:   prdata <= {23'h0, resp_ms_reg};
        `SBL_OFS_STAT:   prdata <= {16'h0, flen_reg, 3'h0, init_busy,
                                    !fifo_in_rdy, link_on,
                                    tx_busy, ready_reg};
        `SBL_OFS_RXIDX:  prdata <= {24'h0, rx_idx_reg};
        `SBL_OFS_RXDATA: prdata <= {24'h0, ram_q};
        `SBL_OFS_BINVAL: prdata <= {16'h0, bin_val_reg};
        `SBL_OFS_ANAVAL: prdata <= {16'h0, ana_val_reg};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // link-written inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_inputs <= 16'h0000;
      ana_input  <= ABSENT_MARK;
    end else if (init_busy) begin
      bin_inputs <= 16'h0000;
      ana_input  <= ABSENT_MARK;
    end else begin
      bin_inputs <= bin_val_reg;
      ana_input  <= ana_val_reg;
    end
  end

  // ==========================================================
  // receiver
  sbl_rx_e     rx_st;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [9:0]  rx_sh;
  logic        rx_done;
  logic [3:0]  rx_last;
  logic [7:0]  rx_byte;
  logic        rx_err;

  // data bits plus parity if any plus one checked stop bit
  assign rx_last = has_par(ctrl_reg.fmt) ? 4'h9 : 4'h8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st   <= SBL_RX_IDLE;
      rx_cnt  <= 16'h0000;
      rx_idx  <= 4'h0;
      rx_sh   <= 10'h000;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      unique case (rx_st)
        SBL_RX_IDLE:
          if (link_on && !rx_in) begin
            rx_st  <= SBL_RX_START;
            rx_cnt <= div >> 1;
          end
        SBL_RX_START:
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            // a glitch shorter than half a bit is no start bit
            rx_st  <= rx_in ? SBL_RX_IDLE : SBL_RX_BITS;
            rx_cnt <= div;
            rx_idx <= 4'h0;
          end
        SBL_RX_BITS:
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            rx_sh  <= {rx_in, rx_sh[9:1]};
            rx_idx <= rx_idx + 4'h1;
            rx_cnt <= div;
            if (rx_idx == rx_last) begin
              rx_st   <= SBL_RX_IDLE;
              rx_done <= 1'b1;
            end
          end
      endcase
      if (!link_on) begin
        rx_st <= SBL_RX_IDLE;
      end
    end
  end

  // unpack the shifted character
  always_comb begin
    if (has_par(ctrl_reg.fmt)) begin
      rx_byte = rx_sh[7:0];
      rx_err  = !rx_sh[9] ||
                (rx_sh[8] != par_bit(rx_sh[7:0], ctrl_reg.fmt));
    end else begin
      rx_byte = rx_sh[8:1];
      rx_err  = !rx_sh[9];
    end
  end

  // ==========================================================
  // frame assembly and end-of-frame silence
  logic [7:0]  len_reg;
  logic [15:0] crc_reg;
  logic        ferr_reg;
  logic [7:0]  dest_reg;
  logic [15:0] sil_cnt;
  logic [5:0]  sil_bits;
  logic        take;

  // bytes are only taken while no frame awaits software
  assign take   = rx_done && link_on && !ready_reg && !tx_busy;
  assign ram_wr = '{we: take, addr: len_reg, data: rx_byte};

  assign frame_end = (sil_bits == `SBL_SILENCE_BITS) &&
                     (len_reg != 8'h00);
  assign frame_ok  = frame_end && !ferr_reg && (crc_reg == 16'h0000) &&
                     (len_reg >= `SBL_MIN_FRAME) &&
                     (dest_reg == station_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_reg  <= 8'h00;
      crc_reg  <= 16'hFFFF;
      ferr_reg <= 1'b0;
      dest_reg <= 8'h00;
    end else if (frame_end || !link_on) begin
      len_reg  <= 8'h00;
      crc_reg  <= 16'hFFFF;
      ferr_reg <= 1'b0;
    end else if (take) begin
      len_reg  <= len_reg + 8'h01;
      crc_reg  <= crc_step(crc_reg, rx_byte);
      // too long a frame is as bad as a broken character
      ferr_reg <= ferr_reg || rx_err || (len_reg == 8'hFF);
      if (len_reg == 8'h00) begin
        dest_reg <= rx_byte;
      end
    end
  end

  // silence measured in bit times while the line idles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sil_cnt  <= 16'h0000;
      sil_bits <= 6'h00;
    end else if (rx_st != SBL_RX_IDLE || !rx_in) begin
      sil_cnt  <= 16'h0000;
      sil_bits <= 6'h00;
    end else if (sil_bits != `SBL_SILENCE_BITS) begin
      if (sil_cnt == div) begin
        sil_cnt  <= 16'h0000;
        sil_bits <= sil_bits + 6'h01;
      end else begin
        sil_cnt <= sil_cnt + 16'h0001;
      end
    end
  end

  // frame flag: a new good frame wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      flen_reg  <= 8'h00;
    end else if (frame_ok) begin
      ready_reg <= 1'b1;
      flen_reg  <= len_reg;
    end else if (clr_ready) begin
      ready_reg <= 1'b0;
    end
  end

  sbl_ram u_ram (
    .pclk    (pclk),
    .wr      (ram_wr),
    .rd_addr (rx_idx_reg),
    .rd_data (ram_q)
  );

  // ==========================================================
  // reply delay
  logic [31:0] ms_cnt;
  logic [8:0]  ms_done;
  logic        resp_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt  <= 32'h00000000;
      ms_done <= 9'h000;
    end else if (frame_ok) begin
      ms_cnt  <= 32'h00000000;
      ms_done <= 9'h000;
    end else if (ms_done != `SBL_RESP_MAX_MS) begin
      if (ms_cnt == 32'(CYC_PER_MS - 1)) begin
        ms_cnt  <= 32'h00000000;
        ms_done <= ms_done + 9'h001;
      end else begin
        ms_cnt <= ms_cnt + 32'h00000001;
      end
    end
  end
  assign resp_ok = (ms_done >= resp_ms_reg);

  // ==========================================================
  // transmitter
  sbl_tx_e     tx_st;
  logic [11:0] tx_sh;
  logic [3:0]  tx_left;
  logic [15:0] tx_cnt;
  logic        tx_char;

  assign tx_busy    = (tx_st != SBL_TX_IDLE);
  assign tx_char    = (tx_left != 4'h0);
  assign fifo_pop   = (tx_st == SBL_TX_SEND) && !tx_char && fifo_vld;
  assign tx_drive_n = (tx_st != SBL_TX_SEND);

  sbl_fifo #(.W(8), .D(16)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (wr_go && wr_tx),
    .in_ready  (fifo_in_rdy),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_q)
  );

  // reply sequencing; only a valid pending frame is answered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= SBL_TX_IDLE;
    end else if (!link_on) begin
      tx_st <= SBL_TX_IDLE;
    end else begin
      unique case (tx_st)
        SBL_TX_IDLE:
          if (tx_go && ready_reg) begin
            tx_st <= SBL_TX_WAIT;
          end
        SBL_TX_WAIT:
          if (resp_ok) begin
            tx_st <= SBL_TX_SEND;
          end
        SBL_TX_SEND:
          if (!tx_char && !fifo_vld) begin
            tx_st <= SBL_TX_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh   <= 12'hFFF;
      tx_left <= 4'h0;
      tx_cnt  <= 16'h0000;
      tx_out  <= 1'b1;
    end else if (!link_on) begin
      tx_left <= 4'h0;
      tx_out  <= 1'b1;
    end else if (fifo_pop) begin
      // stop bits sit above parity; 8N1 sends one fewer bit
      tx_sh   <= has_par(ctrl_reg.fmt) ?
                 {2'b11, par_bit(fifo_q, ctrl_reg.fmt), fifo_q, 1'b0} :
                 {3'b111, fifo_q, 1'b0};
      tx_left <= (ctrl_reg.fmt == SBL_F8N1) ? 4'hA : 4'hB;
      tx_cnt  <= 16'h0000;
    end else if (tx_char) begin
      tx_out <= tx_sh[0];
      if (tx_cnt == div) begin
        tx_cnt  <= 16'h0000;
        tx_sh   <= {1'b1, tx_sh[11:1]};
        tx_left <= tx_left - 4'h1;
      end else begin
        tx_cnt <= tx_cnt + 16'h0001;
      end
    end else begin
      tx_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** sbl_link_checker.sv ***
// port-level assertion checker for the serial slave link
`timescale 1ns/10ps
`default_nettype none
module sbl_link_checker #(
  parameter int          CYC_PER_MS  = 25000,
  parameter logic [15:0] ABSENT_MARK = 16'h7FFF
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // rs485 line
  input wire logic        rx_in,
  input wire logic        tx_out,
  input wire logic        tx_drive_n,
  // device state
  input wire logic        setup_port_busy,
  input wire logic        init_busy,
  // link-written inputs
  input wire logic [15:0] bin_inputs,
  input wire logic [15:0] ana_input
);
  // ==========
  // access decode
  logic acc;
  logic unmapped;
  logic rd_done;
  logic bin_wr;
  assign acc      = psel && penable;
  assign unmapped = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
  assign rd_done  = acc && pready && !pwrite;
  assign bin_wr   = acc && pready && pwrite && (paddr == 8'h20);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bin_init_zero: assert property (init_busy |=> bin_inputs == 16'h0000)
    else $error("binary input not zero during init");
  a_ana_init_mark: assert property (init_busy |=> ana_input == ABSENT_MARK)
    else $error("analog input not absent marker during init");
  a_bin_after_init: assert property (bin_wr && !init_busy ##1 !init_busy
    |=> bin_inputs == $past(pwdata[15:0], 2))
    else $error("written binary value not applied");
  a_link_off_setup: assert property (setup_port_busy |=> tx_drive_n)
    else $error("driver on while setup port busy");
  a_idle_line_high: assert property (tx_drive_n |-> tx_out)
    else $error("line not idle high");
  a_start_after_drive: assert property ($fell(tx_drive_n) |-> ##[0:2] !tx_out)
    else $error("no start bit after driver on");
  a_stop_before_off: assert property ($rose(tx_drive_n) |-> $past(tx_out))
    else $error("driver released before stop level");
  a_unmapped_err: assert property (acc |-> pslverr == unmapped)
    else $error("error response wrong for address");
  a_unmapped_zero: assert property (rd_done && unmapped |=> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_addr_range: assert property (rd_done && paddr == 8'h04
    |=> prdata[31:8] == 24'h0 && prdata[7:0] != 8'h00 && prdata[7:0] <= 8'hFE)
    else $error("station address out of range");
endmodule
bind sbl_link sbl_link_checker #(.CYC_PER_MS(CYC_PER_MS),
  .ABSENT_MARK(ABSENT_MARK)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_in(rx_in), .tx_out(tx_out), .tx_drive_n(tx_drive_n),
  .setup_port_busy(setup_port_busy), .init_busy(init_busy),
  .bin_inputs(bin_inputs), .ana_input(ana_input));
`default_nettype wire

// *** sbl_mstr_model.sv ***
// rs485 bus master model that sends requests and reads replies
`timescale 1ns/10ps
`default_nettype none
module sbl_mstr_model (
  // clock
  input  wire logic              pclk,
  // line toward the device receiver
  output logic                   line_out,
  // device transmitter
  input  wire logic              tx_out,
  input  wire logic              tx_drive_n,
  // character timing and format
  input  wire logic [15:0]       bit_cyc,
  input  wire sbl_pkg::sbl_fmt_e fmt
);
  import sbl_pkg::*;
  // ==========
  // line driver, biased high between frames
  initial line_out = 1'b1;
  task automatic bit_out(input logic v);
    line_out <= v;
    repeat (bit_cyc) @(posedge pclk);
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(posedge pclk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(b[i]);
    if (fmt == SBL_F8O1) bit_out(~^b);
    if (fmt == SBL_F8E1) bit_out(^b);
    bit_out(1'b1);
    if (fmt == SBL_F8N2) bit_out(1'b1);
  endtask
  // mid-cell sampling, parity and stop checked
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int   n;
    logic p;
    n = 0;
    while (tx_out !== 1'b0 && n < 30000) begin
      @(negedge pclk);
      n++;
    end
    repeat (bit_cyc / 2) @(negedge pclk);
    ok = (n < 30000) && (tx_out === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge pclk);
      b[i] = tx_out;
    end
    p = (fmt == SBL_F8O1) ? ~^b : ^b;
    if (fmt == SBL_F8O1 || fmt == SBL_F8E1) begin
      repeat (bit_cyc) @(negedge pclk);
      ok = ok && (tx_out === p);
    end
    repeat (bit_cyc) @(negedge pclk);
    ok = ok && (tx_out === 1'b1) && (tx_drive_n === 1'b0);
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the serial slave link
`timescale 1ns/10ps
`default_nettype none
`include "sbl_map.svh"
module tb_top;
  import sbl_pkg::*;
  localparam int          CPM = 20;
  localparam logic [15:0] AM  = 16'h7FFF;
  // ==========
  // signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rb;
  logic [31:0] pwdata, prdata, q;
  logic        rx_in, tx_out, tx_drive_n, setup_port_busy, init_busy;
  logic        err, rok;
  logic [15:0] bin_inputs, ana_input, bit_cyc;
  logic [7:0]  exp_q [0:16];
  sbl_fmt_e    fmt;
  int          num_errors, tests_run, cyc, t_flag, t_tx, n;
  sbl_link #(.CYC_PER_MS(CPM), .ABSENT_MARK(AM)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out),
    .tx_drive_n(tx_drive_n), .setup_port_busy(setup_port_busy),
    .init_busy(init_busy), .bin_inputs(bin_inputs), .ana_input(ana_input));
  sbl_mstr_model mstr (.pclk(pclk), .line_out(rx_in), .tx_out(tx_out),
    .tx_drive_n(tx_drive_n), .bit_cyc(bit_cyc), .fmt(fmt));
  // 25 MHz clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; read data lands in q, error flag in err
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int   k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20000; k++) begin
      @(posedge pclk);
      if (pready) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20000) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, q & m, e);
  endtask
  // crc of a two-byte request, low byte sent first
  function automatic logic [15:0] crc16(input logic [7:0] a, f);
    logic [15:0] c;
    c = 16'hFFFF ^ {8'h00, a};
    for (int j = 0; j < 16; j++) begin
      if (j == 8) c = c ^ {8'h00, f};
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // request frame at 115200, x corrupts the check word
  task automatic frame(input logic [7:0] a, input logic [15:0] x,
                       input sbl_fmt_e f);
    logic [15:0] c;
    apb(`SBL_OFS_CTRL, 1'b1, {27'h0, 1'b1, 2'h3, f});
    fmt = f;
    c = crc16(a, 8'h03) ^ x;
    mstr.send_byte(a);
    mstr.send_byte(8'h03);
    mstr.send_byte(c[7:0]);
    mstr.send_byte(c[15:8]);
  endtask
  // ==========
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, setup_port_busy} = 5'h00;
    {paddr, pwdata} = 40'h0;
    init_busy = 1'b1;
    {num_errors, tests_run, cyc} = 96'h0;
    fmt = SBL_F8N1;
    bit_cyc = 16'(`SBL_CLK_HZ / 115200 + 1);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl_rst", `SBL_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk("addr_rst", `SBL_OFS_ADDR, 32'hFFFFFFFF, 32'h1);
    rd_chk("resp_rst", `SBL_OFS_RESP, 32'hFFFFFFFF, 32'h28);
    apb(`SBL_OFS_ADDR, 1'b1, 32'h0);
    rd_chk("addr_zero", `SBL_OFS_ADDR, 32'hFF, 32'h1);
    apb(`SBL_OFS_ADDR, 1'b1, 32'hFF);
    rd_chk("addr_255", `SBL_OFS_ADDR, 32'hFF, 32'h1);
    apb(`SBL_OFS_ADDR, 1'b1, 32'hFE);
    rd_chk("addr_254", `SBL_OFS_ADDR, 32'hFF, 32'hFE);
    apb(`SBL_OFS_RESP, 1'b1, 32'h1F5);
    rd_chk("resp_501", `SBL_OFS_RESP, 32'h1FF, 32'h28);
    apb(`SBL_OFS_RESP, 1'b1, 32'h1F4);
    rd_chk("resp_500", `SBL_OFS_RESP, 32'h1FF, 32'h1F4);
    apb(`SBL_OFS_RESP, 1'b1, 32'hA);
    apb(8'h28, 1'b0, 32'h0);
    chk("unmapped", {q[31:1], err}, 32'h1);
    // held inputs during init, applied once it ends
    apb(`SBL_OFS_BINVAL, 1'b1, 32'h1234);
    apb(`SBL_OFS_ANAVAL, 1'b1, 32'h0BCD);
    chk("bin_init", 32'(bin_inputs), 32'h0);
    chk("ana_init", 32'(ana_input), 32'(AM));
    @(posedge pclk);
    init_busy <= 1'b0;
    apb(`SBL_OFS_BINVAL, 1'b1, 32'h00A5);
    repeat (3) @(negedge pclk);
    chk("bin_run", 32'(bin_inputs), 32'h00A5);
    chk("ana_run", 32'(ana_input), 32'h0BCD);
    // every rate and format code, last one leaves 115200 8N1
    for (int b = 0; b < 4; b++) begin
      apb(`SBL_OFS_CTRL, 1'b1, {27'h0, 1'b1, 2'(b), 2'(3 - b)});
      rd_chk("ctrl", `SBL_OFS_CTRL, 32'h1F, {27'h0, 1'b1, 2'(b), 2'(3 - b)});
    end
    @(posedge pclk);
    setup_port_busy <= 1'b1;
    rd_chk("link_off", `SBL_OFS_STAT, 32'h4, 32'h0);
    @(posedge pclk);
    setup_port_busy <= 1'b0;
    rd_chk("link_on", `SBL_OFS_STAT, 32'h4, 32'h4);
    // foreign station in 8E1, then corrupt check word in 8O1
    for (int s = 0; s < 2; s++) begin
      frame(s ? 8'hFE : 8'h01, s ? 16'h0100 : 16'h0, s ? SBL_F8O1 : SBL_F8E1);
      repeat (45 * bit_cyc) @(posedge pclk);
      rd_chk("dropped", `SBL_OFS_STAT, 32'h1, 32'h0);
    end
    // good request in 8N1, fifo filled to full, reply drained
    frame(8'hFE, 16'h0, SBL_F8N1);
    for (n = 0; n < 4000; n++) begin
      apb(`SBL_OFS_STAT, 1'b0, 32'h0);
      if (q[0]) break;
    end
    t_flag = cyc;
    chk("frame_ok", q & 32'hFF01, 32'h0401);
    apb(`SBL_OFS_RXIDX, 1'b1, 32'h1);
    rd_chk("rx_func", `SBL_OFS_RXDATA, 32'hFF, 32'h03);
    for (int i = 0; i < 17; i++) exp_q[i] = 8'(i * 37 + 5);
    for (int i = 0; i < 16; i++) apb(`SBL_OFS_TXDATA, 1'b1, {24'h0, exp_q[i]});
    rd_chk("fifo_full", `SBL_OFS_STAT, 32'h8, 32'h8);
    apb(`SBL_OFS_TXGO, 1'b1, 32'h1);
    fork
      apb(`SBL_OFS_TXDATA, 1'b1, {24'h0, exp_q[16]});
      begin
        for (n = 0; n < 1000 && tx_drive_n !== 1'b0; n++) @(negedge pclk);
        t_tx = cyc;
        chk("resp_wait", 32'(t_tx - t_flag >= 190 && t_tx - t_flag <= 260), 1);
        for (int i = 0; i < 17; i++) begin
          mstr.recv_byte(rb, rok);
          chk("reply", {23'h0, rok, rb}, {24'h1, exp_q[i]});
        end
      end
    join
    for (n = 0; n < 3000 && tx_drive_n !== 1'b1; n++) @(negedge pclk);
    rd_chk("tx_done", `SBL_OFS_STAT, 32'hA, 32'h0);
    apb(`SBL_OFS_STAT, 1'b1, 32'h1);
    rd_chk("cleared", `SBL_OFS_STAT, 32'h1, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
